// ==== lpwu_map.svh ====
`ifndef LPWU_MAP_SVH
`define LPWU_MAP_SVH
// Register addresses
`define LPWU_ADDR_PWR_CTL 8'h87
`define LPWU_ADDR_UNLOCK 8'h8e
// Reset values and fields
`define LPWU_PWR_CTL_RST 8'h00
`define LPWU_UNLOCK_RST 8'h00
`define LPWU_PWR_CTL_RD_MASK 8'hef
`define LPWU_UNLOCK_KEY 8'h55
`define LPWU_BIT_DOZE 0
`define LPWU_BIT_SLEEP 1
// Instructions allowed to drain before the halt
`define LPWU_DRAIN_INSTR 2'd3
// Clock rate and settle times
`define LPWU_CLK_MHZ 40
`define LPWU_T_LONG_US 11000
`define LPWU_T_WDT_US 1000
`define LPWU_T_IRQ_US 500
`define LPWU_CYC_LONG (`LPWU_T_LONG_US * `LPWU_CLK_MHZ)
`define LPWU_CYC_WDT (`LPWU_T_WDT_US * `LPWU_CLK_MHZ)
`define LPWU_CYC_IRQ (`LPWU_T_IRQ_US * `LPWU_CLK_MHZ)
// Dual oscillator clock source codes
`define LPWU_SRC_DUAL_A 4'h3
`define LPWU_SRC_DUAL_B 4'h6
`define LPWU_SRC_DUAL_C 4'ha
`define LPWU_SRC_DUAL_D 4'hd
// Oscillator types
`define LPWU_OSCT_XTAL 2'h0
`define LPWU_OSCT_32K 2'h1
`define LPWU_OSCT_RC 2'h2
// Oscillator settle exponents
`define LPWU_WARM_EXP_00 17
`define LPWU_WARM_EXP_01 14
`define LPWU_WARM_EXP_10 11
`define LPWU_WARM_EXP_11 8
`define LPWU_WARM_EXP_32K 13
`define LPWU_WARM_EXP_RC 7
`endif

// ==== lpwu_pkg.sv ====
`default_nettype none
package lpwu_pkg;
	typedef enum logic [2:0] {
		LPWU_PWR,
		LPWU_OSC,
		LPWU_RUN,
		LPWU_DRAIN,
		LPWU_DOZE,
		LPWU_SLEEP
	} lpwu_state_t;

	typedef struct packed {
		lpwu_state_t st;
		logic [18:0] cnt;
		logic [17:0] osc_cnt;
		logic        use_osc;
		logic        from_rst;
		logic [7:0]  pwr_ctl;
		logic [7:0]  unlock;
		logic        armed;
		logic        clr_req;
		logic [1:0]  drain;
		logic [7:0]  rdata;
		logic        cpu_clk;
		logic        per_clk;
		logic        t3_clk;
		logic        osc_en;
		logic        wdt_run;
		logic        cpu_rst;
		logic        wake_go;
		logic        t3_auto;
	} lpwu_regs_t;
endpackage
`default_nettype wire

// ==== lpwu_ctrl.sv ====
// Notes on behaviour
// R01 - Doze stops CPU clock, peripherals keep running
// R02 - Unlock 0x55 then request bit, consecutive
// R03 - Broken sequence clears unlock or request
// R04 - Doze interrupt wake restores clock, clears bits
// R05 - Reset in suspend clears bits, restarts CPU
// R06 - Single oscillator: deep sleep stops everything
// R07 - Dual oscillator keeps Timer3 low clock; code keeps it only while SYS_CLK_IS_LF is low
// R08 - Watchdog may keep counting in deep sleep
// R09 - Both bits set: deep sleep only
// R10 - External or supply-drop interrupt wakes sleep
// R11 - Timer3 wakes sleep only on low clock
// R12 - Software adds three no-ops after request
// R13 - Bit 1 sleep, bit 0 doze
// R14 - Power settle, then oscillator settle, then run
// R15 - Settle times depend on wake cause
// R16 - Oscillator settle length from option and type
// R17 - Watchdog enable and sleep options
// R18 - Timer3 flag clear option
// R19 - Settle counter on oscillator ticks, gates closed
//
// Local design decision: the address-and-strobe port.
`include "lpwu_map.svh"
`default_nettype none
module lpwu_ctrl #(
	parameter int CYC_LONG = `LPWU_CYC_LONG,
	parameter int CYC_WDT  = `LPWU_CYC_WDT,
	parameter int CYC_IRQ  = `LPWU_CYC_IRQ
) (
	input  wire logic       CLK,
	input  wire logic       RST,
	input  wire logic       CE,
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	input  wire logic       INSTR_END,
	input  wire logic       PIN_RST,
	input  wire logic       WDT_RST,
	input  wire logic       LVR_RST,
	input  wire logic       DOZE_IRQ,
	input  wire logic       EXT_IRQ,
	input  wire logic       LPD_IRQ,
	input  wire logic       T3_IRQ,
	input  wire logic       OSC_TICK,
	input  wire logic [3:0] OPT_CLK_SRC,
	input  wire logic [1:0] OPT_SETTLE,
	input  wire logic [1:0] OSC_TYPE,
	input  wire logic       SYS_CLK_IS_LF,
	input  wire logic       T3_CLK_IS_LF,
	input  wire logic       OPT_WDT_EN,
	input  wire logic       OPT_WDT_SLEEP,
	input  wire logic       OPT_T3_FLAG_CLR,
	output logic            CPU_CLK_EN,
	output logic            PERIPH_CLK_EN,
	output logic            T3_CLK_EN,
	output logic            OSC_EN,
	output logic            WDT_RUN,
	output logic            CPU_RESET,
	output logic            WAKE_GO,
	output logic            T3_FLAG_AUTO_CLR,
	output logic            DOZE_ACTIVE,
	output logic            SLEEP_ACTIVE
);

	////////////////////////////////////////////////////////////////
	// Settle loads, cut to counter width
	localparam logic [18:0] LOAD_LONG = 19'(CYC_LONG - 1);
	localparam logic [18:0] LOAD_WDT  = 19'(CYC_WDT - 1);
	localparam logic [18:0] LOAD_IRQ  = 19'(CYC_IRQ - 1);

	localparam lpwu_pkg::lpwu_regs_t REGS_RST = '{
		st:       lpwu_pkg::LPWU_PWR,
		cnt:      LOAD_LONG,
		osc_cnt:  18'h00000,
		use_osc:  1'b1,
		from_rst: 1'b1,
		pwr_ctl:  `LPWU_PWR_CTL_RST,
		unlock:   `LPWU_UNLOCK_RST,
		armed:    1'b0,
		clr_req:  1'b0,
		drain:    2'h0,
		rdata:    8'h00,
		cpu_clk:  1'b0,
		per_clk:  1'b0,
		t3_clk:   1'b0,
		osc_en:   1'b1,
		wdt_run:  1'b0,
		cpu_rst:  1'b1,
		wake_go:  1'b0,
		t3_auto:  1'b0
	};

	lpwu_pkg::lpwu_regs_t r_reg;
	lpwu_pkg::lpwu_regs_t r_next;

	////////////////////////////////////////////////////////////////
	// Oscillator settle terminal count
	logic [17:0] osc_last;

	always_comb
	begin
		osc_last = 18'(18'h00001 << `LPWU_WARM_EXP_00) - 18'h00001;
		case (OSC_TYPE)
			`LPWU_OSCT_32K:
				osc_last = 18'(18'h00001 << `LPWU_WARM_EXP_32K) - 18'h00001; // R16
			`LPWU_OSCT_RC:
				osc_last = 18'(18'h00001 << `LPWU_WARM_EXP_RC) - 18'h00001; // R16
			default:
			begin
				case (OPT_SETTLE) // R16
					2'h0: osc_last = 18'(18'h00001 << `LPWU_WARM_EXP_00) - 18'h00001;
					2'h1: osc_last = 18'(18'h00001 << `LPWU_WARM_EXP_01) - 18'h00001;
					2'h2: osc_last = 18'(18'h00001 << `LPWU_WARM_EXP_10) - 18'h00001;
					default: osc_last = 18'(18'h00001 << `LPWU_WARM_EXP_11) - 18'h00001;
				endcase
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Clock source decode
	logic dual_src;
	logic lf_keep;
	logic wdt_on;
	logic sleep_wake;
	logic req_wr;

	always_comb
	begin
		dual_src = (OPT_CLK_SRC == `LPWU_SRC_DUAL_A) || (OPT_CLK_SRC == `LPWU_SRC_DUAL_B) ||
			(OPT_CLK_SRC == `LPWU_SRC_DUAL_C) || (OPT_CLK_SRC == `LPWU_SRC_DUAL_D);
		lf_keep = dual_src && !SYS_CLK_IS_LF; // R06 R07
		wdt_on = !OPT_WDT_EN; // R17
		sleep_wake = EXT_IRQ || LPD_IRQ || (T3_IRQ && T3_CLK_IS_LF); // R10 R11
		req_wr = WR && (ADDR == `LPWU_ADDR_PWR_CTL) &&
			(WDATA[`LPWU_BIT_DOZE] || WDATA[`LPWU_BIT_SLEEP]);
	end

	////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		logic        start;
		logic [18:0] load;
		logic        need_osc;
		logic        finish;
		r_next = r_reg;
		start = 1'b0;
		load = LOAD_LONG;
		need_osc = 1'b1;
		finish = 1'b0;
		r_next.wake_go = 1'b0;
		r_next.rdata = 8'h00;

		// Read data for the cycle after the strobe
		if (RD)
		begin
			case (ADDR)
				`LPWU_ADDR_PWR_CTL: r_next.rdata = r_reg.pwr_ctl & `LPWU_PWR_CTL_RD_MASK;
				`LPWU_ADDR_UNLOCK:  r_next.rdata = r_reg.unlock;
				default:            r_next.rdata = 8'h00;
			endcase
		end

		// Resets from pin, supply monitor and watchdog
		if (PIN_RST || LVR_RST)
		begin
			start = 1'b1; // R05
			load = LOAD_LONG; // R15
			need_osc = 1'b1;
		end
		else if (WDT_RST)
		begin
			start = 1'b1; // R05
			load = LOAD_WDT; // R15
			need_osc = (r_reg.st == lpwu_pkg::LPWU_SLEEP); // R15
		end
		else
		begin
			case (r_reg.st)
				lpwu_pkg::LPWU_PWR:
				begin
					if (r_reg.cnt == 19'h00000)
					begin
						if (r_reg.use_osc)
						begin
							r_next.st = lpwu_pkg::LPWU_OSC; // R14
							r_next.osc_cnt = 18'h00000;
						end
						else
						begin
							finish = 1'b1;
						end
					end
					else
					begin
						r_next.cnt = r_reg.cnt - 19'h00001;
					end
				end
				lpwu_pkg::LPWU_OSC:
				begin
					if (OSC_TICK) // R19
					begin
						if (r_reg.osc_cnt == osc_last)
						begin
							finish = 1'b1; // R14
						end
						else
						begin
							r_next.osc_cnt = r_reg.osc_cnt + 18'h00001;
						end
					end
				end
				lpwu_pkg::LPWU_RUN:
				begin
					// Pending clear of a request without unlock
					if (r_reg.clr_req)
					begin
						r_next.pwr_ctl[`LPWU_BIT_DOZE] = 1'b0; // R03
						r_next.pwr_ctl[`LPWU_BIT_SLEEP] = 1'b0; // R03
						r_next.clr_req = 1'b0;
					end
					// Unlock holds only for the next instruction
					if (r_reg.armed && INSTR_END)
					begin
						r_next.armed = 1'b0;
						if (!req_wr)
						begin
							r_next.unlock = 8'h00; // R03
						end
					end
					if (WR && (ADDR == `LPWU_ADDR_UNLOCK))
					begin
						r_next.unlock = WDATA;
						r_next.armed = (WDATA == `LPWU_UNLOCK_KEY); // R02
					end
					if (WR && (ADDR == `LPWU_ADDR_PWR_CTL))
					begin
						r_next.pwr_ctl = WDATA; // R13
						if (req_wr && r_reg.armed)
						begin
							r_next.st = lpwu_pkg::LPWU_DRAIN; // R02
							r_next.drain = 2'h0;
							r_next.armed = 1'b0;
							r_next.clr_req = 1'b0;
						end
						else if (req_wr)
						begin
							r_next.clr_req = 1'b1; // R03
						end
						else if (r_reg.armed)
						begin
							r_next.armed = 1'b0;
							r_next.unlock = 8'h00; // R03
						end
					end
				end
				lpwu_pkg::LPWU_DRAIN:
				begin
					// Let the trailing no-ops leave the pipe
					if (INSTR_END)
					begin
						if (r_reg.drain == `LPWU_DRAIN_INSTR - 2'h1) // R12
						begin
							if (r_reg.pwr_ctl[`LPWU_BIT_SLEEP])
							begin
								r_next.st = lpwu_pkg::LPWU_SLEEP; // R09
							end
							else
							begin
								r_next.st = lpwu_pkg::LPWU_DOZE; // R01
							end
						end
						else
						begin
							r_next.drain = r_reg.drain + 2'h1;
						end
					end
				end
				lpwu_pkg::LPWU_DOZE:
				begin
					if (DOZE_IRQ || EXT_IRQ || LPD_IRQ || T3_IRQ)
					begin
						r_next.st = lpwu_pkg::LPWU_PWR; // R04
						r_next.cnt = LOAD_IRQ; // R15
						r_next.use_osc = 1'b0;
						r_next.from_rst = 1'b0;
					end
				end
				lpwu_pkg::LPWU_SLEEP:
				begin
					if (sleep_wake)
					begin
						r_next.st = lpwu_pkg::LPWU_PWR; // R10 R11
						r_next.cnt = LOAD_IRQ; // R15
						r_next.use_osc = 1'b1; // R15
						r_next.from_rst = 1'b0;
					end
				end
				default:
				begin
					start = 1'b1;
				end
			endcase
		end

		// Start of a reset settle sequence
		if (start)
		begin
			r_next.st = lpwu_pkg::LPWU_PWR; // R05
			r_next.cnt = load;
			r_next.use_osc = need_osc;
			r_next.from_rst = 1'b1;
			r_next.osc_cnt = 18'h00000;
			r_next.pwr_ctl = `LPWU_PWR_CTL_RST; // R05
			r_next.unlock = `LPWU_UNLOCK_RST; // R05
			r_next.armed = 1'b0;
			r_next.clr_req = 1'b0;
			r_next.drain = 2'h0;
		end

		// Return to run after settling
		if (finish)
		begin
			r_next.st = lpwu_pkg::LPWU_RUN;
			r_next.unlock = 8'h00; // R04 R10
			r_next.pwr_ctl[`LPWU_BIT_DOZE] = 1'b0; // R04 R09
			r_next.pwr_ctl[`LPWU_BIT_SLEEP] = 1'b0; // R09 R10
			r_next.wake_go = !r_reg.from_rst; // R04 R10
			r_next.from_rst = 1'b0;
		end

		// CPU held in reset until a reset sequence ends
		if (start)
		begin
			r_next.cpu_rst = 1'b1; // R05
		end
		else if (finish)
		begin
			r_next.cpu_rst = 1'b0; // R14
		end

		// Clock gates and enables from the next state
		r_next.cpu_clk = (r_next.st == lpwu_pkg::LPWU_RUN) ||
			(r_next.st == lpwu_pkg::LPWU_DRAIN); // R01 R19
		r_next.per_clk = r_next.cpu_clk || (r_next.st == lpwu_pkg::LPWU_DOZE); // R01
		r_next.t3_clk = r_next.per_clk ||
			((r_next.st == lpwu_pkg::LPWU_SLEEP) && lf_keep); // R06 R07
		r_next.osc_en = (r_next.st != lpwu_pkg::LPWU_SLEEP); // R06 R10
		r_next.wdt_run = wdt_on &&
			((r_next.st != lpwu_pkg::LPWU_SLEEP) || OPT_WDT_SLEEP); // R08 R17
		r_next.t3_auto = !OPT_T3_FLAG_CLR; // R18
	end

	////////////////////////////////////////////////////////////////
	// State register, frozen while the enable is low
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			r_reg <= REGS_RST;
		end
		else if (CE)
		begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs
	assign RDATA = r_reg.rdata;
	assign CPU_CLK_EN = r_reg.cpu_clk;
	assign PERIPH_CLK_EN = r_reg.per_clk;
	assign T3_CLK_EN = r_reg.t3_clk;
	assign OSC_EN = r_reg.osc_en;
	assign WDT_RUN = r_reg.wdt_run;
	assign CPU_RESET = r_reg.cpu_rst;
	assign WAKE_GO = r_reg.wake_go;
	assign T3_FLAG_AUTO_CLR = r_reg.t3_auto;
	assign DOZE_ACTIVE = (r_reg.st == lpwu_pkg::LPWU_DOZE);
	assign SLEEP_ACTIVE = (r_reg.st == lpwu_pkg::LPWU_SLEEP);

endmodule
`default_nettype wire

// ==== lpwu_cpu_model.sv ====
`default_nettype none
module lpwu_cpu_model
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic cpu_clk_en,
	input  wire logic hold,
	output var logic  instr_end
);
	timeunit 1ns;
	timeprecision 1ps;
	// One instruction a clock while clocked, stalls on hold
	always_ff @(posedge clk or posedge rst)
		if (rst)
			instr_end <= 1'b0;
		else
			instr_end <= cpu_clk_en && !hold;
endmodule
`default_nettype wire

// ==== lpwu_ctrl_sva.sv ====
`default_nettype none
module lpwu_ctrl_sva #(
	parameter int CYC_IRQ = 4
) (
	input wire logic       CLK,
	input wire logic       RST,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	input wire logic       PIN_RST,
	input wire logic       LVR_RST,
	input wire logic       WDT_RST,
	input wire logic       DOZE_IRQ,
	input wire logic       EXT_IRQ,
	input wire logic       LPD_IRQ,
	input wire logic       T3_IRQ,
	input wire logic [3:0] OPT_CLK_SRC,
	input wire logic       SYS_CLK_IS_LF,
	input wire logic       T3_CLK_IS_LF,
	input wire logic       OPT_WDT_EN,
	input wire logic       OPT_WDT_SLEEP,
	input wire logic       OPT_T3_FLAG_CLR,
	input wire logic       CPU_CLK_EN,
	input wire logic       PERIPH_CLK_EN,
	input wire logic       T3_CLK_EN,
	input wire logic       OSC_EN,
	input wire logic       WDT_RUN,
	input wire logic       CPU_RESET,
	input wire logic       WAKE_GO,
	input wire logic       T3_FLAG_AUTO_CLR,
	input wire logic       DOZE_ACTIVE,
	input wire logic       SLEEP_ACTIVE
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIM = CYC_IRQ + 2;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// Steps of a resume
	sequence s_resume;
		CPU_CLK_EN && !CPU_RESET ##1 !WAKE_GO;
	endsequence
	sequence s_restart;
		!SLEEP_ACTIVE && OSC_EN && !CPU_CLK_EN;
	endsequence
	////////////////////////////////////////////////////////////////
	a_doze_gates: assert property (DOZE_ACTIVE |-> !CPU_CLK_EN && PERIPH_CLK_EN)
		else $error("doze gates wrong");
	a_sleep_gates: assert property (SLEEP_ACTIVE |-> !CPU_CLK_EN && !PERIPH_CLK_EN && !OSC_EN)
		else $error("sleep gates wrong");
	a_t3_sleep_clk: assert property (SLEEP_ACTIVE |-> T3_CLK_EN ==
		((OPT_CLK_SRC inside {4'h3, 4'h6, 4'ha, 4'hd}) && !SYS_CLK_IS_LF))
		else $error("timer3 clock wrong");
	a_wdt_run_opt: assert property (!$past(RST) && $stable(OPT_WDT_EN) && $stable(OPT_WDT_SLEEP)
		|-> WDT_RUN == (!OPT_WDT_EN && (!SLEEP_ACTIVE || OPT_WDT_SLEEP)))
		else $error("watchdog run wrong");
	a_t3_auto_opt: assert property (!$past(RST) && $stable(OPT_T3_FLAG_CLR)
		|-> T3_FLAG_AUTO_CLR == !OPT_T3_FLAG_CLR)
		else $error("flag clear option wrong");
	a_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
		else $error("read data not idle");
	a_wake_pulse: assert property (WAKE_GO |-> s_resume)
		else $error("wake pulse wrong");
	a_doze_wake: assert property (DOZE_ACTIVE && DOZE_IRQ |-> ##[1:LIM] WAKE_GO)
		else $error("doze wake late");
	a_sleep_wake: assert property (SLEEP_ACTIVE && (EXT_IRQ || LPD_IRQ) |=> s_restart)
		else $error("sleep wake wrong");
	a_t3_no_wake: assert property (SLEEP_ACTIVE && T3_IRQ && !T3_CLK_IS_LF && !EXT_IRQ
		&& !LPD_IRQ && !PIN_RST && !LVR_RST && !WDT_RST |=> SLEEP_ACTIVE)
		else $error("timer3 woke sleep");
	a_reset_hold: assert property (PIN_RST || LVR_RST |=> CPU_RESET && !CPU_CLK_EN)
		else $error("reset not held");
	a_run_start: assert property ($fell(CPU_RESET) |-> CPU_CLK_EN)
		else $error("run start wrong");
endmodule
bind lpwu_ctrl lpwu_ctrl_sva #(.CYC_IRQ(CYC_IRQ)) i_sva (.*);
`default_nettype wire

// ==== testbench.sv ====
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LONG = 20;
	localparam int WDTC = 8;
	localparam int IRQC = 4;
	logic CLK = 1'b0, RST = 1'b1, CE = 1'b1, WR = 1'b0, RD = 1'b0, OSC_TICK = 1'b1;
	logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
	logic PIN_RST = 1'b0, WDT_RST = 1'b0, LVR_RST = 1'b0, DOZE_IRQ = 1'b0, EXT_IRQ = 1'b0;
	logic LPD_IRQ = 1'b0, T3_IRQ = 1'b0, SYS_CLK_IS_LF = 1'b0, T3_CLK_IS_LF = 1'b0;
	logic OPT_WDT_EN = 1'b0, OPT_WDT_SLEEP = 1'b1, OPT_T3_FLAG_CLR = 1'b0, hold = 1'b0;
	logic [3:0] OPT_CLK_SRC = 4'h3;
	logic [1:0] OPT_SETTLE = 2'h0, OSC_TYPE = 2'h2;
	logic INSTR_END, CPU_CLK_EN, PERIPH_CLK_EN, T3_CLK_EN, OSC_EN, WDT_RUN, CPU_RESET;
	logic WAKE_GO, T3_FLAG_AUTO_CLR, DOZE_ACTIVE, SLEEP_ACTIVE;
	int   fails = 0, n_compared = 0, cyc = 0, n;
	logic [7:0] rows [5][3] = '{'{8'h87, 8'hff, 8'hec}, '{8'h87, 8'h0c, 8'h0c},
		'{8'h8e, 8'h55, 8'h00}, '{8'h40, 8'hab, 8'h00}, '{8'h87, 8'h00, 8'h00}};
	lpwu_ctrl #(.CYC_LONG(LONG), .CYC_WDT(WDTC), .CYC_IRQ(IRQC)) i_dut (.*);
	lpwu_cpu_model i_cpu (.clk(CLK), .rst(RST), .cpu_clk_en(CPU_CLK_EN), .hold(hold),
		.instr_end(INSTR_END));
	always #12.5 CLK = ~CLK;
	////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
	endtask
	task automatic idle();
		WR <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 chk(RDATA, e);
		@(posedge CLK);
	endtask
	task automatic enter(input logic [7:0] pd);
		wr(8'h8e, 8'h55);
		wr(8'h87, pd);
		idle();
		repeat (6) @(posedge CLK);
		#1;
	endtask
	// Waits for a wake pulse or for the run state
	task automatic wt(input bit w, input int lim);
		n = 0;
		do
		begin
			@(posedge CLK);
			#1;
			n++;
		end
		while (n < lim && !(w ? WAKE_GO === 1'b1 : CPU_RESET === 1'b0 && CPU_CLK_EN === 1'b1));
		chk(8'(n < lim), 8'h01);
		@(posedge CLK);
	endtask
	// Cycle ceiling against hangs
	always @(posedge CLK)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			$display("[ERR] %0t timeout", $time);
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge CLK);
		RST <= 1'b0;
		wt(0, 400);
		chk(8'(n == LONG + 128), 8'h01);
		chk(8'(T3_FLAG_AUTO_CLR), 8'h01);
		for (int i = 0; i < 5; i++)
		begin
			wr(rows[i][0], rows[i][1]);
			idle();
			rd(rows[i][0], rows[i][2]);
		end
		$display("registers done");
		wr(8'h8e, 8'h55);
		wr(8'h87, 8'h01);
		hold <= 1'b1;
		idle();
		repeat (4) @(posedge CLK);
		#1 chk(8'(DOZE_ACTIVE), 8'h00);
		@(posedge CLK);
		hold <= 1'b0;
		repeat (6) @(posedge CLK);
		#1 chk({5'h00, DOZE_ACTIVE, PERIPH_CLK_EN, CPU_CLK_EN}, 8'h06);
		@(posedge CLK);
		DOZE_IRQ <= 1'b1;
		wt(1, 20);
		chk(8'(n == IRQC + 1), 8'h01);
		DOZE_IRQ <= 1'b0;
		rd(8'h87, 8'h00);
		rd(8'h8e, 8'h00);
		$display("doze done");
		enter(8'h03);
		chk({4'h0, WDT_RUN, SLEEP_ACTIVE, DOZE_ACTIVE, T3_CLK_EN}, 8'h0d);
		@(posedge CLK);
		T3_IRQ <= 1'b1;
		repeat (8) @(posedge CLK);
		#1 chk(8'(SLEEP_ACTIVE), 8'h01);
		@(posedge CLK);
		T3_CLK_IS_LF <= 1'b1;
		wt(1, 300);
		T3_IRQ <= 1'b0;
		T3_CLK_IS_LF <= 1'b0;
		rd(8'h87, 8'h00);
		$display("dual sleep done");
		OPT_CLK_SRC <= 4'he;
		OPT_WDT_SLEEP <= 1'b0;
		OSC_TYPE <= 2'h0;
		OPT_SETTLE <= 2'h3;
		enter(8'h02);
		chk({3'h0, OSC_EN, PERIPH_CLK_EN, CPU_CLK_EN, T3_CLK_EN, WDT_RUN}, 8'h00);
		@(posedge CLK);
		EXT_IRQ <= 1'b1;
		wt(1, 300);
		chk(8'(n == IRQC + 1 + 256), 8'h01);
		EXT_IRQ <= 1'b0;
		enter(8'h02);
		@(posedge CLK);
		WDT_RST <= 1'b1;
		@(posedge CLK);
		WDT_RST <= 1'b0;
		wt(0, 300);
		chk(8'(n == WDTC + 256), 8'h01);
		rd(8'h8e, 8'h00);
		$display("single sleep done");
		enter(8'h01);
		@(posedge CLK);
		PIN_RST <= 1'b1;
		@(posedge CLK);
		PIN_RST <= 1'b0;
		LVR_RST <= 1'b1;
		@(posedge CLK);
		LVR_RST <= 1'b0;
		#1 chk({6'h00, CPU_RESET, DOZE_ACTIVE}, 8'h02);
		wt(0, 400);
		chk(8'(n == LONG + 256), 8'h01);
		rd(8'h87, 8'h00);
		// Write while the enable is low must be lost
		CE <= 1'b0;
		wr(8'h87, 8'h0c);
		idle();
		CE <= 1'b1;
		rd(8'h87, 8'h00);
		$display("reset done");
		OPT_T3_FLAG_CLR <= 1'b1;
		OPT_WDT_EN <= 1'b1;
		repeat (2) @(posedge CLK);
		#1 chk({6'h00, T3_FLAG_AUTO_CLR, WDT_RUN}, 8'h00);
		$display("options done");
		complete_run();
	end
endmodule
`default_nettype wire
